// ---- hw/led_pkg.sv ----
// Purpose: Shared constants and carriers for the network status indicator driver
// Assumes: 32-bit APB, 10 MHz pclk
// Notes:   One 8-bit control field per indicator inside the control register
package led_pkg;

  localparam int unsigned NUM_IND     = 4;
  localparam int unsigned IND_FIELD_W = 8;
  localparam int unsigned ADDR_W      = 12;

  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_STATUS   = 12'h004;
  localparam logic [11:0] ADDR_RELOAD   = 12'h008;
  localparam logic [11:0] ADDR_DEFAULTS = 12'h01c;

  // Field positions inside one indicator field
  localparam int unsigned FLD_SRC_LSB   = 0;
  localparam int unsigned FLD_SRC_W     = 4;
  localparam int unsigned FLD_RSVD_BIT  = 4;
  localparam int unsigned FLD_RATE_BIT  = 5;
  localparam int unsigned FLD_INV_BIT   = 6;
  localparam int unsigned FLD_BLINK_BIT = 7;

  // Defaults word layout: indicator 1 low byte, indicator 3 high byte
  localparam int unsigned DEF_IND1_LSB = 0;
  localparam int unsigned DEF_IND3_LSB = 8;
  localparam int unsigned DEF_W        = 16;

  // Status register layout
  localparam int unsigned ST_IND_LSB    = 0;
  localparam int unsigned ST_SLOW_BIT   = 4;
  localparam int unsigned ST_FAST_BIT   = 5;
  localparam int unsigned ST_LINK_BIT   = 8;
  localparam int unsigned ST_SPEED_LSB  = 9;
  localparam int unsigned ST_DUPLEX_BIT = 11;
  localparam int unsigned ST_ACT_BIT    = 12;
  localparam int unsigned ST_COLL_BIT   = 13;
  localparam int unsigned ST_PAUSE_BIT  = 14;

  localparam int unsigned RELOAD_BIT = 0;

  // Reset values
  localparam logic [7:0]  CTRL_IND0_RESET = 8'h02;
  localparam logic [7:0]  CTRL_IND2_RESET = 8'h06;
  localparam logic [15:0] DEFAULTS_RESET  = 16'h0783;
  localparam logic [7:0]  RSVD_MASK       = 8'hef;

  // Indicator source codes
  localparam logic [3:0] SRC_LINK_10_1000  = 4'h0;
  localparam logic [3:0] SRC_LINK_100_1000 = 4'h1;
  localparam logic [3:0] SRC_LINK_UP       = 4'h2;
  localparam logic [3:0] SRC_FILT_ACTIVITY = 4'h3;
  localparam logic [3:0] SRC_LINK_IDLE     = 4'h4;
  localparam logic [3:0] SRC_LINK_10       = 4'h5;
  localparam logic [3:0] SRC_LINK_100      = 4'h6;
  localparam logic [3:0] SRC_LINK_1000     = 4'h7;
  localparam logic [3:0] SRC_PIN_MIRROR    = 4'h8;
  localparam logic [3:0] SRC_FULL_DUPLEX   = 4'h9;
  localparam logic [3:0] SRC_COLLISION     = 4'ha;
  localparam logic [3:0] SRC_ACTIVITY      = 4'hb;
  localparam logic [3:0] SRC_BUS_SIZE      = 4'hc;
  localparam logic [3:0] SRC_PAUSED        = 4'hd;
  localparam logic [3:0] SRC_FORCE_ON      = 4'he;
  localparam logic [3:0] SRC_FORCE_OFF     = 4'hf;

  // Link speed codes
  localparam logic [1:0] SPEED_10   = 2'h0;
  localparam logic [1:0] SPEED_100  = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;

  // Blink timing
  localparam int unsigned CLK_HZ            = 10_000_000;
  localparam int unsigned BLINK_SLOW_MS     = 200;
  localparam int unsigned BLINK_FAST_MS     = 83;
  localparam int unsigned SLOW_HALF_CYCLES  = BLINK_SLOW_MS * (CLK_HZ / 1000);
  localparam int unsigned FAST_HALF_CYCLES  = BLINK_FAST_MS * (CLK_HZ / 1000);

  typedef struct packed {
    logic       blink;
    logic       invert;
    logic       rate;
    logic       rsvd;
    logic [3:0] src;
  } ind_cfg_s;

  typedef struct packed {
    logic       link_up;
    logic [1:0] speed;
    logic       full_duplex;
    logic       filt_activity;
    logic       any_activity;
    logic       collision;
    logic       single_lane;
    logic       tx_paused;
  } link_status_s;

endpackage

// ---- hw/blink_timer.sv ----
// Purpose: Shared free-running blink phase generator
// Assumes: Half periods of at least two cycles
// Notes:   One phase per blink rate, index 0 slow, index 1 fast
`timescale 1ns/1ps
module blink_timer
  import led_pkg::*;
#(
  parameter int unsigned SLOW_HALF = SLOW_HALF_CYCLES,
  parameter int unsigned FAST_HALF = FAST_HALF_CYCLES
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  output logic      [1:0] phase
);

  localparam int unsigned CNT_W = $clog2(SLOW_HALF > FAST_HALF ? SLOW_HALF : FAST_HALF) + 1;

  genvar r;
  generate
    for (r = 0; r < 2; r++) begin : g_rate
      localparam logic [CNT_W-1:0] LAST = CNT_W'((r == 0 ? SLOW_HALF : FAST_HALF) - 1);
      logic [CNT_W-1:0] cnt;
      logic             ph;
      wire              wrap = (cnt == LAST);

      // One process per phase bit; the port bit is a plain copy
      assign phase[r] = ph;

      // Free-running, never gated, so all indicators on one rate share one phase
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt <= '0;
          ph  <= 1'b1;
        end else if (wrap) begin
          cnt <= '0;
          ph  <= ~ph;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  endgenerate

endmodule

// ---- hw/network_status_led_driver.sv ----
// Purpose: Four status indicator outputs of a gigabit network controller
// Assumes: Status inputs synchronous to pclk; APB master per AMBA APB
// Notes:   Indicator pins are active low; reload command copies defaults word
//
// Summary of operation
// - Code 0 shows 10 or 1000 link; code 1 shows 100 or 1000 link.
// - Code 2 shows link up at any speed.
// - Code 3 shows link with filtered frame activity.
// - Code 4 shows link up with no transmit or receive activity.
// - Codes 5, 6, 7 show link at exactly 10, 100, 1000 Mb/s.
// - Code 8 mirrors software pin of same index.
// - Code 9 shows full duplex configuration.
// - Code 10 shows an observed collision.
// - Code 11 shows link with any frame activity.
// - Code 12 shows single-lane host bus connection.
// - Code 13 shows transmitter held off by flow control.
// - Asserted indicator drives its pin low, deasserted drives high.
// - Invert bit flips the selected source before blinking.
// - Blink bit toggles the output periodically while asserted.
// - Rate 0 blinks 200 ms on/off, rate 1 blinks 83 ms on/off.
// - Indicators 1 and 3 take defaults from the defaults word.
// - Variant: link-idle source off, steady on idle, blinking on activity.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module network_status_led_driver
  import led_pkg::*;
#(
  parameter int unsigned SLOW_HALF      = SLOW_HALF_CYCLES,
  parameter int unsigned FAST_HALF      = FAST_HALF_CYCLES,
  parameter bit          LINKACT_STYLE  = 1'b0,
  parameter logic [7:0]  IND0_DEFAULT   = CTRL_IND0_RESET,
  parameter logic [7:0]  IND2_DEFAULT   = CTRL_IND2_RESET
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic       [31:0] pwdata,
  input  wire logic        [3:0] pstrb,
  output logic            [31:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire link_status_s      link_status,
  input  wire logic [NUM_IND-1:0] software_definable_pin,
  output logic     [NUM_IND-1:0] led_n
);

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [31:0]    indicator_control_register;
  logic [DEF_W-1:0] indicator_1_3_defaults_word;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire setup_phase  = psel & ~penable;
  wire access_done  = psel & penable & pready;
  wire write_fire   = access_done & pwrite;
  wire word_aligned = (paddr[1:0] == 2'h0);

  wire hit_ctrl     = word_aligned & (paddr == ADDR_CTRL);
  wire hit_status   = word_aligned & (paddr == ADDR_STATUS);
  wire hit_reload   = word_aligned & (paddr == ADDR_RELOAD);
  wire hit_defaults = word_aligned & (paddr == ADDR_DEFAULTS);
  wire hit_any      = hit_ctrl | hit_status | hit_reload | hit_defaults;

  // Status register is read only; writing it is an error
  wire bad_access   = ~hit_any | (pwrite & hit_status);

  wire wr_ctrl      = write_fire & hit_ctrl & ~pslverr;
  wire wr_defaults  = write_fire & hit_defaults & ~pslverr;
  wire wr_reload    = write_fire & hit_reload & ~pslverr & pstrb[0] & pwdata[RELOAD_BIT];

  // ---------------------------------------------------------------
  // Byte-lane write merge, reserved bits forced to zero
  // ---------------------------------------------------------------
  wire [31:0] strb_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [31:0] rsvd_keep = {RSVD_MASK, RSVD_MASK, RSVD_MASK, RSVD_MASK};
  wire [31:0] ctrl_merge = ((pwdata & strb_mask) | (indicator_control_register & ~strb_mask)) & rsvd_keep;

  wire [15:0] def_strb  = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [15:0] def_keep  = {RSVD_MASK, RSVD_MASK};
  wire [15:0] def_merge = ((pwdata[15:0] & def_strb) | (indicator_1_3_defaults_word & ~def_strb)) & def_keep;

  // Reload copies defaults into indicators 1 and 3, leaving 0 and 2
  wire [7:0]  def_ind1  = indicator_1_3_defaults_word[DEF_IND1_LSB +: IND_FIELD_W];
  wire [7:0]  def_ind3  = indicator_1_3_defaults_word[DEF_IND3_LSB +: IND_FIELD_W];
  wire [31:0] ctrl_reload = {def_ind3,
                             indicator_control_register[2*IND_FIELD_W +: IND_FIELD_W],
                             def_ind1,
                             indicator_control_register[0 +: IND_FIELD_W]};

  wire [31:0] next_ctrl = wr_ctrl   ? ctrl_merge :
                          wr_reload ? ctrl_reload :
                                      indicator_control_register;

  wire [15:0] next_defaults = wr_defaults ? def_merge : indicator_1_3_defaults_word;

  // Power-on control value: indicators 1 and 3 from the defaults word reset value, 0 and 2 from IND0_DEFAULT and IND2_DEFAULT
  localparam logic [31:0] CTRL_RESET = {DEFAULTS_RESET[DEF_IND3_LSB +: IND_FIELD_W],
                                        IND2_DEFAULT,
                                        DEFAULTS_RESET[DEF_IND1_LSB +: IND_FIELD_W],
                                        IND0_DEFAULT};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      indicator_control_register  <= CTRL_RESET;
      indicator_1_3_defaults_word <= DEFAULTS_RESET;
    end else begin
      indicator_control_register  <= next_ctrl;
      indicator_1_3_defaults_word <= next_defaults;
    end
  end

  // ---------------------------------------------------------------
  // Shared blink timebase
  // ---------------------------------------------------------------
  logic [1:0] blink_phase;

  blink_timer #(
    .SLOW_HALF (SLOW_HALF),
    .FAST_HALF (FAST_HALF)
  ) u_blink_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .phase   (blink_phase)
  );

  // ---------------------------------------------------------------
  // Common link conditions
  // ---------------------------------------------------------------
  wire link_up    = link_status.link_up;
  wire is_10      = link_up & (link_status.speed == SPEED_10);
  wire is_100     = link_up & (link_status.speed == SPEED_100);
  wire is_1000    = link_up & (link_status.speed == SPEED_1000);
  wire any_act    = link_status.any_activity;
  wire filt_act   = link_status.filt_activity;

  wire cond_10_1000  = is_10 | is_1000;
  wire cond_100_1000 = is_100 | is_1000;
  wire cond_link     = link_up;
  wire cond_filt     = link_up & filt_act;
  wire cond_idle     = link_up & ~any_act;
  wire cond_duplex   = link_status.full_duplex;
  wire cond_coll     = link_status.collision;
  wire cond_act      = link_up & any_act;
  wire cond_lane     = link_status.single_lane;
  wire cond_pause    = link_status.tx_paused;

  // ---------------------------------------------------------------
  // Per-indicator source, invert and blink
  // ---------------------------------------------------------------
  logic [NUM_IND-1:0] ind_on;

  genvar i;
  generate
    for (i = 0; i < NUM_IND; i++) begin : g_ind
      ind_cfg_s cfg;
      logic     src;
      logic     flipped;
      logic     phase_sel;
      logic     variant_path;
      logic     on;

      assign cfg = ind_cfg_s'(indicator_control_register[i*IND_FIELD_W +: IND_FIELD_W]);

      always_comb begin
        case (cfg.src)
          SRC_LINK_10_1000:  src = cond_10_1000;
          SRC_LINK_100_1000: src = cond_100_1000;
          SRC_LINK_UP:       src = cond_link;
          SRC_FILT_ACTIVITY: src = cond_filt;
          SRC_LINK_IDLE:     src = cond_idle;
          SRC_LINK_10:       src = is_10;
          SRC_LINK_100:      src = is_100;
          SRC_LINK_1000:     src = is_1000;
          SRC_PIN_MIRROR:    src = software_definable_pin[i];
          SRC_FULL_DUPLEX:   src = cond_duplex;
          SRC_COLLISION:     src = cond_coll;
          SRC_ACTIVITY:      src = cond_act;
          SRC_BUS_SIZE:      src = cond_lane;
          SRC_PAUSED:        src = cond_pause;
          SRC_FORCE_ON:      src = 1'b1;
          SRC_FORCE_OFF:     src = 1'b0;
          default:           src = 1'b0;
        endcase
      end

      assign flipped   = src ^ cfg.invert;
      assign phase_sel = blink_phase[cfg.rate];

      // Variant: steady on when idle, blinking under activity
      assign variant_path = LINKACT_STYLE & (cfg.src == SRC_LINK_IDLE);

      always_comb begin
        if (!cfg.blink) begin
          on = flipped;
        end else if (variant_path) begin
          on = (link_up & ~any_act) ^ cfg.invert ? 1'b1 : (link_up & phase_sel);
        end else begin
          on = flipped & phase_sel;
        end
      end

      assign ind_on[i] = on;
    end
  endgenerate

  // Active-low pins, dark from reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_n <= '1;
    end else begin
      led_n <= ~ind_on;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [31:0] status_word;

  always_comb begin
    status_word = 32'h0;
    status_word[ST_IND_LSB +: NUM_IND]  = ~led_n;
    status_word[ST_SLOW_BIT]            = blink_phase[0];
    status_word[ST_FAST_BIT]            = blink_phase[1];
    status_word[ST_LINK_BIT]            = link_status.link_up;
    status_word[ST_SPEED_LSB +: 2]      = link_status.speed;
    status_word[ST_DUPLEX_BIT]          = link_status.full_duplex;
    status_word[ST_ACT_BIT]             = link_status.any_activity;
    status_word[ST_COLL_BIT]            = link_status.collision;
    status_word[ST_PAUSE_BIT]           = link_status.tx_paused;
  end

  wire [31:0] read_value = hit_ctrl     ? indicator_control_register :
                           hit_status   ? status_word :
                           hit_defaults ? {16'h0, indicator_1_3_defaults_word} :
                                          32'h0;

  // Answer prepared in the setup cycle, so every access has one wait-free access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase & bad_access;
      prdata  <= (setup_phase & ~pwrite & ~bad_access) ? read_value : 32'h0;
    end
  end

endmodule

// ---- test/indicator_lamps.sv ----
// Purpose: Lamp model standing on the active-low indicator pins
// Assumes: One lamp per pin, lit while its pin is driven low
// Notes:   Purely combinational, no lamp delay modelled
`timescale 1ns/1ps
module indicator_lamps
  import led_pkg::*;
(
  input  wire logic [NUM_IND-1:0] led_n,
  output logic      [NUM_IND-1:0] lit
);
  assign lit = ~led_n;
endmodule

// ---- test/led_driver_properties.sv ----
// Purpose: Port-level properties of the indicator driver
// Assumes: Bench blink halves of 8 and 3 cycles
// Notes:   Shadows the indicator 0 control byte from APB writes
`timescale 1ns/1ps
module led_driver_properties
  import led_pkg::*;
#(
  parameter int unsigned SLOW_HALF = SLOW_HALF_CYCLES,
  parameter int unsigned FAST_HALF = FAST_HALF_CYCLES
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [ADDR_W-1:0]  paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [3:0]         pstrb,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire link_status_s       link_status,
  input wire logic [NUM_IND-1:0] software_definable_pin,
  input wire logic [NUM_IND-1:0] led_n
);
  logic [7:0] c0;
  wire        ctrl_wr = psel && penable && pready && pwrite && !pslverr && paddr == ADDR_CTRL && pstrb[0];
  wire        is_gig  = link_status.link_up && link_status.speed == SPEED_1000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c0 <= CTRL_IND0_RESET;
    end else if (ctrl_wr) begin
      c0 <= pwdata[7:0];
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Lamp just lit with a blink setting held for two cycles
  sequence lit_start(logic [7:0] cfg);
    $past(c0, 2) == cfg && $past(c0) == cfg && $fell(led_n[0]);
  endsequence
  sequence slow_lit;
    (!led_n[0]) [*8] ##1 led_n[0];
  endsequence
  sequence fast_lit;
    (!led_n[0]) [*3] ##1 led_n[0];
  endsequence

  a_ready_after_setup: assert property (psel && !penable |=> pready && psel && penable)
    else $error("no ready in access cycle");
  a_ready_only_access: assert property (pready |-> psel && penable && $past(psel && !penable))
    else $error("ready outside an access cycle");
  a_unmapped_error: assert property (psel && !penable && paddr == 12'h010 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_link_up_src: assert property (c0 == 8'h02 |=> led_n[0] == !$past(link_status.link_up))
    else $error("link up source wrong");
  a_exact_speed: assert property (c0 == 8'h07 |=> led_n[0] == !$past(is_gig))
    else $error("exact speed source wrong");
  a_pin_mirror: assert property (c0 == 8'h08 |=> led_n[0] == !$past(software_definable_pin[0]))
    else $error("pin mirror wrong");
  a_force_levels: assert property (c0 inside {8'h0e, 8'h0f} |=> led_n[0] == $past(c0[0]))
    else $error("forced level wrong");
  a_invert_flip: assert property (c0 == 8'h42 |=> led_n[0] == $past(link_status.link_up))
    else $error("inverted source wrong");
  a_slow_blink: assert property (lit_start(8'h8e) |-> slow_lit)
    else $error("slow blink period wrong");
  a_fast_blink: assert property (lit_start(8'hae) |-> fast_lit)
    else $error("fast blink period wrong");
endmodule

bind network_status_led_driver led_driver_properties #(.SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF)) props_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .link_status(link_status), .software_definable_pin(software_definable_pin), .led_n(led_n)
);

// ---- test/network_status_led_driver_tb.sv ----
// Purpose: Self-checking bench for the indicator driver
// Assumes: Blink halves shortened to 8 and 3 cycles
// Notes:   Indicator 0 carries most source checks
`timescale 1ns/1ps
module network_status_led_driver_tb
  import led_pkg::*;
;
  localparam int unsigned SLOW = 8;
  localparam int unsigned FAST = 3;
  localparam logic [44:0] PATS = {9'h1c0, 9'h18f, 9'h178, 9'h100, 9'h03f};

  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0]  paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic [3:0]         pstrb;
  link_status_s       link_status;
  logic [NUM_IND-1:0] software_definable_pin, led_n, lit;
  int                 fail_count, checks;

  always #50 pclk = ~pclk;

  network_status_led_driver #(.SLOW_HALF(SLOW), .FAST_HALF(FAST)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_status(link_status), .software_definable_pin(software_definable_pin), .led_n(led_n)
  );
  indicator_lamps lamps_u (.led_n(led_n), .lit(lit));

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task finish_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin fail_count++; $display("ERROR pready timeout"); finish_test(); end
  endtask

  task rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'hf);
    chk(name, rd, exp);
  endtask

  function automatic logic src_exp(input logic [3:0] c, input link_status_s s, input logic p);
    case (c)
      4'h0: return s.link_up && (s.speed == SPEED_10 || s.speed == SPEED_1000);
      4'h1: return s.link_up && (s.speed == SPEED_100 || s.speed == SPEED_1000);
      4'h2: return s.link_up;
      4'h3: return s.link_up && s.filt_activity;
      4'h4: return s.link_up && !s.any_activity;
      4'h5: return s.link_up && s.speed == SPEED_10;
      4'h6: return s.link_up && s.speed == SPEED_100;
      4'h7: return s.link_up && s.speed == SPEED_1000;
      4'h8: return p;
      4'h9: return s.full_duplex;
      4'ha: return s.collision;
      4'hb: return s.link_up && s.any_activity;
      4'hc: return s.single_lane;
      4'hd: return s.tx_paused;
      4'he: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  task run_len(input int i, input int exp);
    int n;
    // Let a just-written setting reach the pins first
    @(posedge pclk);
    #1;
    n = 0;
    while (lit[i] !== 1'b0 && n < 40) begin @(posedge pclk); #1; n++; end
    n = 0;
    while (lit[i] !== 1'b1 && n < 40) begin @(posedge pclk); #1; n++; end
    n = 0;
    while (lit[i] === 1'b1 && n < 40) begin @(posedge pclk); #1; n++; end
    chk("lit run", n, exp);
  endtask

  task t_reset_regs;
    rdchk("control reset", ADDR_CTRL, 32'h0706_8302);
    rdchk("defaults reset", ADDR_DEFAULTS, 32'h0000_0783);
    apb(1'b0, 12'h010, 32'h0, 4'hf);
    chk("unmapped error", {31'h0, err}, 32'h1);
    apb(1'b0, 12'h002, 32'h0, 4'hf);
    chk("misaligned error", {31'h0, err}, 32'h1);
    apb(1'b1, ADDR_STATUS, 32'hffff, 4'hf);
    chk("status write error", {31'h0, err}, 32'h1);
  endtask

  task t_sources;
    logic e;
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, ADDR_CTRL, {28'h0, c[3:0]}, 4'h1);
      for (int p = 0; p < 5; p++) begin
        @(posedge pclk);
        link_status <= link_status_s'(PATS[9*p +: 9]);
        software_definable_pin <= {NUM_IND{p[0]}};
        repeat (2) @(posedge pclk);
        #1;
        e = src_exp(c[3:0], link_status_s'(PATS[9*p +: 9]), p[0]);
        chk("source", {31'h0, lit[0]}, {31'h0, e});
      end
    end
  endtask

  task t_invert;
    apb(1'b1, ADDR_CTRL, 32'h0000_0042, 4'h1);
    for (int u = 0; u < 2; u++) begin
      @(posedge pclk);
      link_status <= link_status_s'({u[0], 8'h00});
      repeat (2) @(posedge pclk);
      #1;
      chk("inverted", {31'h0, lit[0]}, {31'h0, !u[0]});
    end
    apb(1'b1, ADDR_CTRL, 32'h0000_004e, 4'h1);
    repeat (2) @(posedge pclk);
    #1;
    chk("inverted force on", {31'h0, lit[0]}, 32'h0);
  endtask

  task t_blink;
    // Every indicator on one rate, invert clear, activity only blinking
    apb(1'b1, ADDR_CTRL, 32'h8b8e_8e8e, 4'hf);
    run_len(1, SLOW);
    for (int k = 0; k < 20; k++) begin
      @(posedge pclk);
      #1;
      chk("in phase", {31'h0, lit[2]}, {31'h0, lit[0]});
      chk("blink dark source", {31'h0, lit[3]}, 32'h0);
    end
    run_len(0, SLOW);
    apb(1'b1, ADDR_CTRL, 32'h8bae_aeae, 4'hf);
    run_len(0, FAST);
    run_len(2, FAST);
  endtask

  task t_reload;
    // Reserved bits 4 and 12 written high, read back low
    apb(1'b1, ADDR_DEFAULTS, 32'h0000_3fba, 4'h3);
    rdchk("defaults rw", ADDR_DEFAULTS, 32'h0000_2faa);
    apb(1'b1, ADDR_CTRL, 32'h0, 4'b1010);
    rdchk("control cleared", ADDR_CTRL, 32'h00ae_00ae);
    apb(1'b1, ADDR_RELOAD, 32'h1, 4'h1);
    rdchk("reloaded", ADDR_CTRL, 32'h2fae_aaae);
    rdchk("reload reads zero", ADDR_RELOAD, 32'h0);
  endtask

  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; pstrb = '0; link_status = '0; software_definable_pin = '0;
    fail_count = 0;
    checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_regs();
    t_sources();
    t_invert();
    t_blink();
    t_reload();
    finish_test();
  end
endmodule
